//--- hdl/nvac_regs.vh
// Register selects, control bit positions and timing counts for the
// nonvolatile data store access controller.
// Assumes a core clock of 125 MHz and a 1 MHz write timing tick.
`ifndef NVAC_REGS_VH
`define NVAC_REGS_VH

// Register selects on the I/O port
`define NVAC_SEL_ADDR_LO 2'h0
`define NVAC_SEL_ADDR_HI 2'h1
`define NVAC_SEL_DATA 2'h2
`define NVAC_SEL_CTRL 2'h3

// Control register bit positions
`define NVAC_BIT_READ_STROBE 0
`define NVAC_BIT_WRITE_BUSY 1
`define NVAC_BIT_MASTER_UNLOCK 2
`define NVAC_BIT_READY_IRQ_EN 3

// Geometry
`define NVAC_ADDR_W 9
`define NVAC_DATA_W 8
`define NVAC_DEPTH 512

// Timing
`define NVAC_CORE_CLK_HZ 125000000
`define NVAC_OSC_HZ 1000000
`define NVAC_OSC_DIV (`NVAC_CORE_CLK_HZ / `NVAC_OSC_HZ)
`define NVAC_WRITE_OSC_CYCLES 8448
`define NVAC_UNLOCK_CYCLES 4
`define NVAC_READ_STALL_CYCLES 4
`define NVAC_WRITE_STALL_CYCLES 2

`endif

//--- hdl/nvac_tick.v
// Divider making the 1 MHz write timing tick from the core clock.
// Assumes core_clk_i is free running; tick_o is a one-cycle pulse.
`timescale 1ns/1ps
module nvac_tick #(
   parameter DIV = 125
) (
   input wire core_clk_i,
   input wire rst_i,
   output reg tick_o
);
   reg [15:0] count;

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         count <= 16'h0000;
         tick_o <= 1'b0;
      end else if (count == DIV[15:0] - 16'h0001) begin
         count <= 16'h0000;
         tick_o <= 1'b1;
      end else begin
         count <= count + 16'h0001;
         tick_o <= 1'b0;
      end
   end
endmodule // nvac_tick

//--- hdl/nvac_array.v
// Byte array standing in for the nonvolatile cells.
// Assumes one registered write port and an asynchronous read port; never reset.
`timescale 1ns/1ps
module nvac_array #(
   parameter AW = 9,
   parameter DW = 8,
   parameter DEPTH = 512
) (
   input wire core_clk_i,
   input wire we_i,
   input wire [AW-1:0] waddr_i,
   input wire [DW-1:0] wdata_i,
   input wire [AW-1:0] raddr_i,
   output wire [DW-1:0] rdata_o
);
   reg [DW-1:0] mem [0:DEPTH-1];

   always @(posedge core_clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   assign rdata_o = mem[raddr_i];
endmodule // nvac_array

//--- hdl/nvac_top.v
// Access controller for a 512-byte nonvolatile data store, seen by the
// core as four byte registers on a simple I/O port.
// Assumes I/O strobes are synchronous one-cycle pulses on core_clk_i and
// that the core honours cpu_stall_o before its next instruction.
`timescale 1ns/1ps
`include "nvac_regs.vh"
module nvac_top #(
   parameter WRITE_OSC_CYCLES = `NVAC_WRITE_OSC_CYCLES,
   parameter OSC_DIV = `NVAC_OSC_DIV
) (
   input wire core_clk_i,
   input wire rst_i,
   input wire pwr_on_rst_i,
   input wire [1:0] io_sel_i,
   input wire io_wr_i,
   input wire io_rd_i,
   input wire [7:0] io_wdata_i,
   input wire global_ie_i,
   input wire flash_selfprog_enable_i,
   output reg [7:0] io_rdata_o,
   output reg cpu_stall_o,
   output reg ready_irq_o
);
   // Counts cut to their counter widths
   localparam integer WR_LAST_INT = WRITE_OSC_CYCLES - 1;
   localparam integer UNLOCK_LAST_INT = `NVAC_UNLOCK_CYCLES - 1;
   localparam integer READ_STALL_INT = `NVAC_READ_STALL_CYCLES;
   localparam integer WRITE_STALL_INT = `NVAC_WRITE_STALL_CYCLES;
   localparam [13:0] WR_LAST = WR_LAST_INT[13:0];
   localparam [2:0] UNLOCK_LAST = UNLOCK_LAST_INT[2:0];
   localparam [2:0] READ_STALL = READ_STALL_INT[2:0];
   localparam [2:0] WRITE_STALL = WRITE_STALL_INT[2:0];

   // Software-visible registers
   reg [`NVAC_ADDR_W-1:0] nv_address;
   reg [`NVAC_DATA_W-1:0] nv_data_byte;
   reg ready_irq_enable;
   reg master_write_unlock;
   reg [2:0] unlock_left;

   // Write engine, survives rst_i
   reg write_strobe_busy;
   reg [13:0] write_left;
   reg [`NVAC_ADDR_W-1:0] eng_addr;
   reg [`NVAC_DATA_W-1:0] eng_data;

   reg [2:0] stall_left;

   wire osc_tick;
   wire [`NVAC_DATA_W-1:0] cell_rdata;

   wire wr_addr_lo = io_wr_i && (io_sel_i == `NVAC_SEL_ADDR_LO);
   wire wr_addr_hi = io_wr_i && (io_sel_i == `NVAC_SEL_ADDR_HI);
   wire wr_data = io_wr_i && (io_sel_i == `NVAC_SEL_DATA);
   wire wr_ctrl = io_wr_i && (io_sel_i == `NVAC_SEL_CTRL);

   // Strobe acceptance
   wire write_accept = wr_ctrl && io_wdata_i[`NVAC_BIT_WRITE_BUSY]
                       && master_write_unlock && !write_strobe_busy;
   wire read_accept = wr_ctrl && io_wdata_i[`NVAC_BIT_READ_STROBE]
                      && !write_strobe_busy && !write_accept;

   // Cell programming waits out any flash self-programming
   wire osc_step = write_strobe_busy && osc_tick && !flash_selfprog_enable_i;
   wire cell_commit = osc_step && (write_left == 14'h0000);

   nvac_tick #(
      .DIV(OSC_DIV)
   ) u_tick (
      .core_clk_i(core_clk_i),
      .rst_i(pwr_on_rst_i),
      .tick_o(osc_tick)
   );

   nvac_array #(
      .AW(`NVAC_ADDR_W),
      .DW(`NVAC_DATA_W),
      .DEPTH(`NVAC_DEPTH)
   ) u_cells (
      .core_clk_i(core_clk_i),
      .we_i(cell_commit),
      .waddr_i(eng_addr),
      .wdata_i(eng_data),
      .raddr_i(nv_address),
      .rdata_o(cell_rdata)
   );

   // Address register, frozen while a write runs
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         nv_address <= 9'h000;
      end else if (!write_strobe_busy) begin
         if (wr_addr_lo) begin
            nv_address[7:0] <= io_wdata_i;
         end
         if (wr_addr_hi) begin
            nv_address[8] <= io_wdata_i[0];
         end
      end
   end

   // Data register: software load or read result
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         nv_data_byte <= 8'h00;
      end else if (read_accept) begin
         nv_data_byte <= cell_rdata;
      end else if (wr_data) begin
         nv_data_byte <= io_wdata_i;
      end
   end

   // Interrupt enable
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         ready_irq_enable <= 1'b0;
      end else if (wr_ctrl) begin
         ready_irq_enable <= io_wdata_i[`NVAC_BIT_READY_IRQ_EN];
      end
   end

   // Unlock window: armed on a 0-to-1 write, closes after four cycles.
   // Writing the bit back as one does not re-arm an open window.
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         master_write_unlock <= 1'b0;
         unlock_left <= 3'h0;
      end else if (wr_ctrl && !io_wdata_i[`NVAC_BIT_MASTER_UNLOCK]) begin
         master_write_unlock <= 1'b0;
         unlock_left <= 3'h0;
      end else if (wr_ctrl && !master_write_unlock) begin
         master_write_unlock <= 1'b1;
         unlock_left <= UNLOCK_LAST;
      end else if (master_write_unlock) begin
         if (unlock_left == 3'h0) begin
            master_write_unlock <= 1'b0;
         end else begin
            unlock_left <= unlock_left - 3'h1;
         end
      end
   end

   // Write engine, cleared only by power-on reset
   always @(posedge core_clk_i) begin
      if (pwr_on_rst_i) begin
         write_strobe_busy <= 1'b0;
         write_left <= 14'h0000;
         eng_addr <= 9'h000;
         eng_data <= 8'h00;
      end else if (write_accept) begin
         write_strobe_busy <= 1'b1;
         write_left <= WR_LAST;
         eng_addr <= nv_address;
         eng_data <= nv_data_byte;
      end else if (cell_commit) begin
         write_strobe_busy <= 1'b0;
      end else if (osc_step) begin
         write_left <= write_left - 14'h0001;
      end
   end

   // Core stall after an accepted strobe
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         stall_left <= 3'h0;
         cpu_stall_o <= 1'b0;
      end else if (write_accept) begin
         stall_left <= WRITE_STALL;
         cpu_stall_o <= 1'b1;
      end else if (read_accept) begin
         stall_left <= READ_STALL;
         cpu_stall_o <= 1'b1;
      end else begin
         if (stall_left != 3'h0) begin
            stall_left <= stall_left - 3'h1;
         end
         cpu_stall_o <= (stall_left > 3'h1);
      end
   end

   // Level ready request, no latched flag
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         ready_irq_o <= 1'b0;
      end else begin
         ready_irq_o <= ready_irq_enable && global_ie_i && !write_strobe_busy;
      end
   end

   // Register read port, answer one cycle after io_rd_i
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         io_rdata_o <= 8'h00;
      end else if (io_rd_i) begin
         case (io_sel_i)
            `NVAC_SEL_ADDR_LO: begin
               io_rdata_o <= nv_address[7:0];
            end
            `NVAC_SEL_ADDR_HI: begin
               io_rdata_o <= {7'h00, nv_address[8]};
            end
            `NVAC_SEL_DATA: begin
               io_rdata_o <= nv_data_byte;
            end
            `NVAC_SEL_CTRL: begin
               io_rdata_o <= {4'h0, ready_irq_enable, master_write_unlock,
                              write_strobe_busy, 1'b0};
            end
            default: begin
               io_rdata_o <= 8'h00;
            end
         endcase
      end else begin
         io_rdata_o <= 8'h00;
      end
   end
endmodule // nvac_top

//--- test/nvac_top_asserts.sv
// Port checker for nvac_top, bound to every instance.
// Assumes one core clock with rst_i as the disable.
`timescale 1ns/1ps
module nvac_top_asserts (
   input wire core_clk_i,
   input wire rst_i,
   input wire [1:0] io_sel_i,
   input wire io_wr_i,
   input wire io_rd_i,
   input wire [7:0] io_wdata_i,
   input wire global_ie_i,
   input wire [7:0] io_rdata_o,
   input wire cpu_stall_o,
   input wire ready_irq_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   rdata_idle_a: assert property (!$past(io_rd_i) |-> io_rdata_o == 8'h00)
      else $error("read data not idle");
   ctrl_zero_a: assert property ($past(io_rd_i) && $past(io_sel_i) == 2'h3 |->
      io_rdata_o[7:4] == 4'h0 && !io_rdata_o[0]) else $error("control spare bits set");
   hi_zero_a: assert property ($past(io_rd_i) && $past(io_sel_i) == 2'h1 |->
      io_rdata_o[7:1] == 7'h00) else $error("address spare bits set");
   stall_cause_a: assert property ($rose(cpu_stall_o) |-> $past(io_wr_i)
      && $past(io_sel_i) == 2'h3 && $past(io_wdata_i[1:0]) != 2'h0)
      else $error("stray stall");
   read_stall_a: assert property ($rose(cpu_stall_o) && $past(io_wdata_i[1:0]) == 2'h1
      |-> cpu_stall_o [*4] ##1 !cpu_stall_o) else $error("read stall length");
   write_stall_a: assert property ($rose(cpu_stall_o) && $past(io_wdata_i[1:0]) == 2'h2
      |-> cpu_stall_o [*2] ##1 !cpu_stall_o) else $error("write stall length");
   irq_gate_a: assert property (ready_irq_o |-> $past(global_ie_i))
      else $error("irq without global enable");
   busy_irq_a: assert property ($rose(cpu_stall_o) && $past(io_wdata_i[1:0]) == 2'h2
      |-> ##1 !ready_irq_o) else $error("irq while busy");
   cover property ($rose(cpu_stall_o) && $past(io_wdata_i[1:0]) == 2'h1);
   cover property ($rose(cpu_stall_o) && $past(io_wdata_i[1:0]) == 2'h2);
   cover property ($rose(ready_irq_o));
endmodule // nvac_top_asserts
bind nvac_top nvac_top_asserts nvac_top_asserts_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .io_sel_i(io_sel_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
   .global_ie_i(global_ie_i), .io_rdata_o(io_rdata_o), .cpu_stall_o(cpu_stall_o),
   .ready_irq_o(ready_irq_o));

//--- test/nvac_top_tb_top.sv
// Self-checking bench for nvac_top with shortened write timing.
// Assumes the checker file is compiled first.
`timescale 1ns/1ps
module nvac_top_tb_top;
   logic core_clk_i = 1'h0, rst_i = 1'h1, pwr_on_rst_i = 1'h1, io_wr_i = 1'h0;
   logic io_rd_i = 1'h0, global_ie_i = 1'h0, flash_selfprog_enable_i = 1'h0;
   logic cpu_stall_o, ready_irq_o;
   logic [1:0] io_sel_i = 2'h0;
   logic [7:0] io_wdata_i = 8'h00, io_rdata_o, q;
   logic [16:0] rows [4] = '{17'h000A5, 17'h1FF3C, 17'h10001, 17'h0AAFF};
   int bad_count = 0, compares = 0;
   always #4 core_clk_i = ~core_clk_i;
   nvac_top #(.WRITE_OSC_CYCLES(40), .OSC_DIV(2)) nvac_top_i (.core_clk_i(core_clk_i),
      .rst_i(rst_i), .pwr_on_rst_i(pwr_on_rst_i), .io_sel_i(io_sel_i), .io_wr_i(io_wr_i),
      .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .global_ie_i(global_ie_i),
      .flash_selfprog_enable_i(flash_selfprog_enable_i), .io_rdata_o(io_rdata_o),
      .cpu_stall_o(cpu_stall_o), .ready_irq_o(ready_irq_o));
   task results;
      $display("Mismatches %0d of %0d compares", bad_count, compares);
      if (bad_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task wr(input logic [1:0] s, input logic [7:0] d);
      @(posedge core_clk_i);
      io_sel_i <= s;
      io_wdata_i <= d;
      io_wr_i <= 1'h1;
      @(posedge core_clk_i);
      io_wr_i <= 1'h0;
   endtask
   task rd(input logic [1:0] s);
      @(posedge core_clk_i);
      io_sel_i <= s;
      io_rd_i <= 1'h1;
      @(posedge core_clk_i);
      io_rd_i <= 1'h0;
      @(negedge core_clk_i);
      q = io_rdata_o;
   endtask
   task wait_idle;
      for (int n = 0; n < 100; n++) begin
         rd(2'h3);
         if (q[1] === 1'h0)
            break;
      end
      chk(8'h00, {7'h00, q[1]});
   endtask
   task put(input logic [8:0] a, input logic [7:0] d, input logic [7:0] c);
      wr(2'h0, a[7:0]);
      wr(2'h1, {7'h7F, a[8]});
      wr(2'h2, d);
      wr(2'h3, c | 8'h04);
      wr(2'h3, c | 8'h06);
      repeat (4) @(posedge core_clk_i);
   endtask
   task get(input logic [8:0] a);
      wr(2'h0, a[7:0]);
      wr(2'h1, {7'h00, a[8]});
      wr(2'h3, 8'h01);
      @(negedge core_clk_i);
      chk(8'h01, {7'h00, cpu_stall_o});
      repeat (4) @(negedge core_clk_i);
      chk(8'h00, {7'h00, cpu_stall_o});
      rd(2'h2);
   endtask
   initial begin
      repeat (5000) @(posedge core_clk_i);
      bad_count++;
      results;
   end
   initial begin
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'h0;
      pwr_on_rst_i <= 1'h0;
      rd(2'h3);
      chk(8'h00, q);
      foreach (rows[k]) begin
         put(rows[k][16:8], rows[k][7:0], 8'h00);
         wait_idle;
         rd(2'h1);
         chk({7'h00, rows[k][16]}, q);
         get(rows[k][16:8]);
         chk(rows[k][7:0], q);
      end
      // Unlock window closes by itself
      wr(2'h3, 8'h04);
      rd(2'h3);
      chk(8'h04, q);
      repeat (2) @(posedge core_clk_i);
      rd(2'h3);
      chk(8'h00, q);
      wr(2'h3, 8'h02);
      repeat (4) @(posedge core_clk_i);
      rd(2'h3);
      chk(8'h00, q);
      // Busy period, ready level, address lock
      @(posedge core_clk_i);
      global_ie_i <= 1'h1;
      put(9'h007, 8'h3C, 8'h08);
      @(negedge core_clk_i);
      chk(8'h00, {7'h00, ready_irq_o});
      wr(2'h0, 8'h55);
      wr(2'h2, 8'h5A);
      wr(2'h3, 8'h09);
      repeat (5) @(posedge core_clk_i);
      rd(2'h3);
      chk(8'h0A, q);
      repeat (40) @(posedge core_clk_i);
      rd(2'h3);
      chk(8'h0A, q);
      repeat (30) @(posedge core_clk_i);
      rd(2'h3);
      chk(8'h08, q);
      chk(8'h01, {7'h00, ready_irq_o});
      rd(2'h0);
      chk(8'h07, q);
      rd(2'h2);
      chk(8'h5A, q);
      get(9'h007);
      chk(8'h3C, q);
      // Enable back on so the global gate has something to hide
      wr(2'h3, 8'h08);
      repeat (2) @(negedge core_clk_i);
      chk(8'h01, {7'h00, ready_irq_o});
      @(posedge core_clk_i);
      global_ie_i <= 1'h0;
      repeat (2) @(negedge core_clk_i);
      chk(8'h00, {7'h00, ready_irq_o});
      @(posedge core_clk_i);
      global_ie_i <= 1'h1;
      wr(2'h3, 8'h00);
      repeat (2) @(negedge core_clk_i);
      chk(8'h00, {7'h00, ready_irq_o});
      // Flash programming holds the cell write
      @(posedge core_clk_i);
      flash_selfprog_enable_i <= 1'h1;
      put(9'h010, 8'hC3, 8'h00);
      repeat (150) @(posedge core_clk_i);
      rd(2'h3);
      chk(8'h02, q);
      @(posedge core_clk_i);
      flash_selfprog_enable_i <= 1'h0;
      wait_idle;
      get(9'h010);
      chk(8'hC3, q);
      // Reset during a write
      put(9'h020, 8'h99, 8'h00);
      rst_i <= 1'h1;
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'h0;
      rd(2'h3);
      chk(8'h02, q);
      wait_idle;
      get(9'h020);
      chk(8'h99, q);
      results;
   end
endmodule // nvac_top_tb_top
